// File: cwss_map.vh
`ifndef CWSS_MAP_VH
`define CWSS_MAP_VH
// Register byte offsets (word aligned)
`define CWSS_OFF_CTRL  8'h00
`define CWSS_OFF_POL   8'h04
`define CWSS_OFF_SHDN  8'h08
`define CWSS_OFF_SRC   8'h0C
`define CWSS_OFF_STR   8'h10
`define CWSS_OFF_CLK   8'h14
`define CWSS_OFF_SEL   8'h18
`define CWSS_OFF_STAT  8'h1C
// Reset values
`define CWSS_RST_CTRL  4'h0
`define CWSS_RST_POL   4'h0
`define CWSS_RST_SHDN  7'h14
`define CWSS_RST_SRC   5'h00
`define CWSS_RST_STR   8'h00
`define CWSS_RST_CLK   1'b0
`define CWSS_RST_SEL   4'h0
// Field positions
`define CWSS_CTRL_EN   3
`define CWSS_MODE      2:0
`define CWSS_SH_FLAG   7
`define CWSS_SH_REN    6
`define CWSS_SH_LSBD   5:4
`define CWSS_SH_LSAC   3:2
`define CWSS_STR_OVR   7:4
`define CWSS_STR_EN    3:0
`define CWSS_SRC_CELL2 4
`define CWSS_SRC_CMP2  3
`define CWSS_SRC_CMP1  2
`define CWSS_SRC_TMR   1
`define CWSS_SRC_PIN   0
// Operating modes
`define CWSS_MODE_ASTEER 3'b000
`define CWSS_MODE_SSTEER 3'b001
// Shutdown level codes
`define CWSS_SDL_HIGH  2'b11
`define CWSS_SDL_LOW   2'b10
`define CWSS_SDL_HIZ   2'b01
`define CWSS_SDL_INACT 2'b00
`define CWSS_WB_ZERO   32'h0000_0000
`endif

// File: cwss_switch_stage.sv
`timescale 1ns/100ps
// Gate drive of the switch stage; a released gate is pulled low
module cwss_switch_stage (
    input  wire [3:0] steered_out, // Drive levels
    input  wire [3:0] steered_oe,  // Drive enables
    output wire [3:0] pin_lvl      // Resolved gate levels
);
// Pull-down wins whenever the block lets go of a pin
assign pin_lvl = steered_out & steered_oe;
endmodule // cwss_switch_stage

// File: cwss_top.v
// Notes on behaviour
// - Source enable bit 4 gates logic cell two output as shutdown trigger.
// - Source enable bit 3 gates second comparator as shutdown trigger.
// - Source enable bit 2 gates first comparator as shutdown trigger.
// - Source enable bit 1 gates timer postscaler as shutdown trigger.
// - Source enable bit 0 gates routed shutdown pin as trigger.
// - Steer enable set drives output with waveform after its polarity.
// - Steer enable clear drives output with its override level bit.
// - Steer and override bits apply only in the two steering modes.
// - Synchronous steering loads steer enables at a rising input edge.
// - Clock select one runs logic from fast oscillator, zero from clock.
// - Selector codes pick pin, capture, PWM 3-6, oscillator, cells.
// - Codes 1000 and 1001 pick first and second comparator.
// - Codes 1110 and 1111 connect no source.
// - Mode 001 is synchronous steering, 000 asynchronous steering.
// - Auto-restart clears shutdown when sources low; resume on rise.
// - Polarity bit one inverts steered waveform, zero passes it.
`timescale 1ns/100ps
`include "cwss_map.vh"

module cwss_top (
    input  wire        ref_clk,                // 250 MHz system clock
    input  wire        sys_rst,                // Synchronous reset
    input  wire        wb_cyc_i,               // Bus cycle
    input  wire        wb_stb_i,               // Bus strobe
    input  wire        wb_we_i,                // Write enable
    input  wire [7:0]  wb_adr_i,               // Byte address
    input  wire [3:0]  wb_sel_i,               // Byte lanes
    input  wire [31:0] wb_dat_i,               // Write data
    output reg  [31:0] wb_dat_o,               // Read data
    output reg         wb_ack_o,               // Acknowledge
    input  wire        internal_fast_oscillator, // 16 MHz level
    input  wire        routed_input_pin,       // Source code 0000
    input  wire        capture_out,            // Source code 0001
    input  wire [3:0]  pwm_out,                // PWM 3..6, codes 0011..0110
    input  wire        osc_out,                // Source code 0111
    input  wire        cmp1_out,               // First comparator
    input  wire        cmp2_out,               // Second comparator
    input  wire [3:0]  logic_cell_out,         // Cells 1..4
    input  wire        timer_postscale_out,    // Timer postscaler
    input  wire        shutdown_pin_route,     // Routed shutdown pin
    output reg  [3:0]  steered_out,            // Outputs D..A
    output reg  [3:0]  steered_oe,             // Drive enables D..A
    output reg         module_clk_sel          // Clock select state
);

    ////////////////////////////////////////////////////////////////////
    // Shutdown state machine, one-hot
    // RUN steers, SHUT holds shutdown levels, WAIT waits for a rising input
    localparam [2:0] ST_RUN  = 3'b001;
    localparam [2:0] ST_SHUT = 3'b010;
    localparam [2:0] ST_WAIT = 3'b100;

    // Software visible registers first, then internal state
    reg  [3:0]  ctrl_reg;       // Enable and mode
    reg  [3:0]  pol_reg;        // Polarity per output
    reg  [6:0]  shdn_reg;       // Restart, level codes (flag separate)
    reg         flag_reg;       // Shutdown status
    reg  [4:0]  src_reg;        // Shutdown source enables
    reg  [7:0]  str_reg;        // Overrides and steer enables
    reg         clk_reg;        // Clock select
    reg  [3:0]  sel_reg;        // Waveform input select
    reg  [3:0]  steer_en_reg;   // Buffered steer enables
    reg         in_reg;         // Sampled waveform input
    reg         osc_d_reg;      // Oscillator edge history
    reg  [2:0]  state_reg;
    reg  [2:0]  state_next;
    reg         flag_next;
    reg  [31:0] rdata;
    reg  [3:0]  out_next;
    reg  [3:0]  oe_next;
    reg  [1:0]  lvl;
    integer     i;

    wire        en      = ctrl_reg[`CWSS_CTRL_EN];
    wire [2:0]  mode    = ctrl_reg[`CWSS_MODE];
    wire        req     = wb_cyc_i & wb_stb_i;
    wire        wr_fire = req & wb_we_i & wb_ack_o & wb_sel_i[0];
    wire [3:0]  ovr_lvl = str_reg[`CWSS_STR_OVR];  // Override levels D..A
    wire        restart_en = shdn_reg[`CWSS_SH_REN]; // Auto-restart enable
    wire [1:0]  code_bd = shdn_reg[`CWSS_SH_LSBD]; // B/D shutdown level
    wire [1:0]  code_ac = shdn_reg[`CWSS_SH_LSAC]; // A/C shutdown level

    ////////////////////////////////////////////////////////////////////
    // Level for one output during shutdown: {oe, value}
    function [1:0] sd_level;
        input [1:0] code;
        input       pol;
        begin
            case (code)
                `CWSS_SDL_HIGH:  sd_level = 2'b11;
                `CWSS_SDL_LOW:   sd_level = 2'b10;
                `CWSS_SDL_HIZ:   sd_level = 2'b00;
                default:         sd_level = {1'b1, pol};
            endcase
        end
    endfunction

    // Address match for a write on lane 0
    function wr_hit;
        input [7:0] adr;
        input [7:0] off;
        begin
            wr_hit = (adr == off);
        end
    endfunction

    ////////////////////////////////////////////////////////////////////
    // One write strobe per register; each fires only at the edge that
    // sees ack high, so a write lands exactly once per bus cycle.
    wire wr_ctrl = wr_fire & wr_hit(wb_adr_i, `CWSS_OFF_CTRL);
    wire wr_pol  = wr_fire & wr_hit(wb_adr_i, `CWSS_OFF_POL);
    wire wr_shdn = wr_fire & wr_hit(wb_adr_i, `CWSS_OFF_SHDN);
    wire wr_src  = wr_fire & wr_hit(wb_adr_i, `CWSS_OFF_SRC);
    wire wr_str  = wr_fire & wr_hit(wb_adr_i, `CWSS_OFF_STR);
    wire wr_clk  = wr_fire & wr_hit(wb_adr_i, `CWSS_OFF_CLK);
    wire wr_sel  = wr_fire & wr_hit(wb_adr_i, `CWSS_OFF_SEL);

    ////////////////////////////////////////////////////////////////////
    // Time base: in oscillator mode only its rising edges advance
    // the waveform logic; the bus side always runs on ref_clk.
    // The oscillator is sampled as a level, so it must stay well below
    // half of ref_clk; a faster source would lose edges.
    wire osc_rise = internal_fast_oscillator & ~osc_d_reg;
    wire step     = clk_reg ? osc_rise : 1'b1;

    ////////////////////////////////////////////////////////////////////
    // Waveform input selector
    // Decoded every clock so the input value reads back in either
    // time base.
    reg sel_in;
    always @* begin
        case (sel_reg)
            4'h0: sel_in = routed_input_pin;
            4'h1: sel_in = capture_out;
            4'h3: sel_in = pwm_out[0];
            4'h4: sel_in = pwm_out[1];
            4'h5: sel_in = pwm_out[2];
            4'h6: sel_in = pwm_out[3];
            4'h7: sel_in = osc_out;
            4'h8: sel_in = cmp1_out;
            4'h9: sel_in = cmp2_out;
            4'hA: sel_in = logic_cell_out[0];
            4'hB: sel_in = logic_cell_out[1];
            4'hC: sel_in = logic_cell_out[2];
            4'hD: sel_in = logic_cell_out[3];
            // Reserved codes and unlisted 0010 tie low
            default: sel_in = 1'b0;
        endcase
    end

    wire in_rise = step & sel_in & ~in_reg;

    ////////////////////////////////////////////////////////////////////
    // Shutdown request: enabled sources ORed together
    // Sources are taken as synchronous levels; a pulse shorter than
    // one clock is not seen.
    wire shut_req =
        (src_reg[`CWSS_SRC_CELL2] & logic_cell_out[1]) |
        (src_reg[`CWSS_SRC_CMP2]  & cmp2_out)          |
        (src_reg[`CWSS_SRC_CMP1]  & cmp1_out)          |
        (src_reg[`CWSS_SRC_TMR]   & timer_postscale_out) |
        (src_reg[`CWSS_SRC_PIN]   & shutdown_pin_route);

    // Status flag: hardware set beats software or auto clear
    // Set is applied last so a live source cannot be cleared away
    always @* begin
        flag_next = flag_reg;
        if (wr_shdn)
            flag_next = wb_dat_i[`CWSS_SH_FLAG];
        if (restart_en && !shut_req && flag_reg)
            flag_next = 1'b0;
        if (en && shut_req)
            flag_next = 1'b1;
    end

    ////////////////////////////////////////////////////////////////////
    // Shutdown sequencing: hold levels until first rise after clear
    // so a restart never cuts into the middle of an input pulse.
    always @* begin
        case (state_reg)
            ST_RUN:  state_next = flag_reg ? ST_SHUT : ST_RUN;
            ST_SHUT: state_next = flag_reg ? ST_SHUT : ST_WAIT;
            ST_WAIT: begin
                if (flag_reg)
                    state_next = ST_SHUT;
                else if (in_rise)
                    state_next = ST_RUN;
                else
                    state_next = ST_WAIT;
            end
            default: state_next = ST_RUN;
        endcase
    end

    ////////////////////////////////////////////////////////////////////
    // Output levels per channel (bit 0 = A, bit 3 = D)
    // Shutdown outranks the enable so software can park the pins first
    always @* begin
        out_next = steered_out;
        oe_next  = steered_oe;
        lvl      = 2'b00;
        for (i = 0; i < 4; i = i + 1) begin
            // B and D share one level code, A and C the other
            if (i[0])
                lvl = sd_level(code_bd, pol_reg[i]);
            else
                lvl = sd_level(code_ac, pol_reg[i]);
            if (state_reg != ST_RUN) begin
                oe_next[i]  = lvl[1];
                out_next[i] = lvl[0];
            end else if (!en) begin
                oe_next[i]  = 1'b0;
                out_next[i] = 1'b0;
            end else if (mode == `CWSS_MODE_ASTEER ||
                         mode == `CWSS_MODE_SSTEER) begin
                oe_next[i] = 1'b1;
                if (steer_en_reg[i])
                    out_next[i] = sel_in ^ pol_reg[i];
                else
                    out_next[i] = ovr_lvl[i];
            end else begin
                // Bridge modes live elsewhere; park at inactive level
                oe_next[i]  = 1'b1;
                out_next[i] = pol_reg[i];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Register writes, taken at the edge that sees ack high
    // Unmapped offsets decode to no strobe, so such writes are dropped
    always @(posedge ref_clk) begin
        if (sys_rst) begin
            ctrl_reg <= `CWSS_RST_CTRL;
            pol_reg  <= `CWSS_RST_POL;
            shdn_reg <= `CWSS_RST_SHDN;
            src_reg  <= `CWSS_RST_SRC;
            str_reg  <= `CWSS_RST_STR;
            clk_reg  <= `CWSS_RST_CLK;
            sel_reg  <= `CWSS_RST_SEL;
        end else begin
            if (wr_ctrl)
                ctrl_reg <= {wb_dat_i[7], wb_dat_i[`CWSS_MODE]};
            if (wr_pol)
                pol_reg  <= wb_dat_i[3:0];
            if (wr_shdn)
                shdn_reg <= wb_dat_i[6:0];
            if (wr_src)
                src_reg  <= wb_dat_i[4:0];
            if (wr_str)
                str_reg  <= wb_dat_i[7:0];
            if (wr_clk)
                clk_reg  <= wb_dat_i[0];
            if (wr_sel)
                sel_reg  <= wb_dat_i[3:0];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Flag runs every clock so a source is never missed
    // even while the waveform side waits for an oscillator edge.
    always @(posedge ref_clk) begin
        if (sys_rst)
            flag_reg <= 1'b0;
        else
            flag_reg <= flag_next;
    end

    ////////////////////////////////////////////////////////////////////
    // Steer enable buffer: immediate in async mode; in sync mode
    // loaded at a rising input edge so a pulse is never chopped.
    // While disabled the buffer tracks the register, ready for enable.
    always @(posedge ref_clk) begin
        if (sys_rst)
            steer_en_reg <= 4'h0;
        else if (mode == `CWSS_MODE_SSTEER) begin
            if (in_rise || !en)
                steer_en_reg <= str_reg[`CWSS_STR_EN];
        end else
            steer_en_reg <= str_reg[`CWSS_STR_EN];
    end

    ////////////////////////////////////////////////////////////////////
    // Waveform side: advances only on the selected time base
    // Outputs hold between oscillator edges, which keeps them clean
    always @(posedge ref_clk) begin
        if (sys_rst) begin
            osc_d_reg      <= 1'b0;
            in_reg         <= 1'b0;
            state_reg      <= ST_RUN;
            steered_out    <= 4'h0;
            steered_oe     <= 4'h0;
            module_clk_sel <= 1'b0;
        end else begin
            osc_d_reg      <= internal_fast_oscillator;
            module_clk_sel <= clk_reg;
            if (step) begin
                in_reg      <= sel_in;
                state_reg   <= state_next;
                steered_out <= out_next;
                steered_oe  <= oe_next;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Read mux; unmapped addresses read zero
    // The status word exposes internal state for test software; it is
    // read-only and writes to it are dropped.
    always @* begin
        rdata = `CWSS_WB_ZERO;
        case (wb_adr_i)
            `CWSS_OFF_CTRL: rdata[7:0] = {ctrl_reg[3], 4'h0, ctrl_reg[2:0]};
            `CWSS_OFF_POL:  rdata[7:0] = {2'b00, in_reg, 1'b0, pol_reg};
            `CWSS_OFF_SHDN: rdata[7:0] = {flag_reg, shdn_reg[6:2], 2'b00};
            `CWSS_OFF_SRC:  rdata[7:0] = {3'b000, src_reg};
            `CWSS_OFF_STR:  rdata[7:0] = str_reg;
            `CWSS_OFF_CLK:  rdata[7:0] = {7'h00, clk_reg};
            `CWSS_OFF_SEL:  rdata[7:0] = {4'h0, sel_reg};
            `CWSS_OFF_STAT: rdata[15:0] = {state_reg, steer_en_reg,
                                           flag_reg, steered_oe,
                                           steered_out};
            default: ;
        endcase
    end

    ////////////////////////////////////////////////////////////////////
    // Ack one cycle after the request; dropped the cycle after,
    // which forces an idle cycle between back-to-back accesses.
    // Read data is latched with the ack so it stands for that cycle.
    always @(posedge ref_clk) begin
        if (sys_rst) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= `CWSS_WB_ZERO;
        end else begin
            wb_ack_o <= req & ~wb_ack_o;
            if (req && !wb_ack_o)
                wb_dat_o <= rdata;
        end
    end

endmodule // cwss_top

// File: cwss_top_monitor.sv
`timescale 1ns/100ps
`include "cwss_map.vh"
module cwss_top_monitor (
    input wire        ref_clk,                  // Clock
    input wire        sys_rst,                  // Reset
    input wire        wb_cyc_i,                 // Cycle
    input wire        wb_stb_i,                 // Strobe
    input wire        wb_we_i,                  // Write
    input wire [7:0]  wb_adr_i,                 // Address
    input wire [3:0]  wb_sel_i,                 // Lanes
    input wire [31:0] wb_dat_i,                 // Write data
    input wire        wb_ack_o,                 // Answer
    input wire        internal_fast_oscillator, // Osc level
    input wire        routed_input_pin,         // Code 0
    input wire        capture_out,              // Code 1
    input wire [3:0]  pwm_out,                  // Codes 3-6
    input wire        osc_out,                  // Code 7
    input wire        cmp1_out,                 // Code 8
    input wire        cmp2_out,                 // Code 9
    input wire [3:0]  logic_cell_out,           // Codes 10-13
    input wire        timer_postscale_out,      // Trip source
    input wire        shutdown_pin_route,       // Trip source
    input wire [3:0]  steered_out,              // Levels
    input wire [3:0]  steered_oe,               // Enables
    input wire        module_clk_sel            // Clock select
);
////////////////////////////////////////////////////////////////////////////
reg  [7:0]  ctl, pol, shd, src, str, sel; // Shadow registers
reg         ck, trip;
reg  [1:0]  qt;                           // Cycles since a write
wire        wr = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o & wb_sel_i[0];
wire [15:0] wv = {2'h0, logic_cell_out, cmp2_out, cmp1_out, osc_out,
                  pwm_out, 1'b0, capture_out, routed_input_pin};
wire [4:0]  sd = {logic_cell_out[1], cmp2_out, cmp1_out,
                  timer_postscale_out, shutdown_pin_route};
wire        hot = ctl[7] & (|(src[4:0] & sd));
wire [3:0]  ex = (({4{wv[sel[3:0]]}} ^ pol[3:0]) & str[3:0])
               | (str[7:4] & ~str[3:0]);
// Trips leave a parked state behind, so steering is judged only before one
wire        calm = (qt == 2'h3) & ~trip & ~hot & ~ck & ~module_clk_sel;

// Shadow copies follow acknowledged writes
always @(posedge ref_clk) begin
    if (sys_rst) begin
        {ctl, pol, src, str, sel} <= 40'h00_0000_0000;
        shd <= 8'h14;
        {ck, trip, qt} <= 4'h0;
    end else begin
        qt <= wr ? 2'h0 : qt + {1'b0, qt != 2'h3};
        trip <= trip | hot | shd[7];
        if (wr && wb_adr_i == `CWSS_OFF_CTRL) ctl <= wb_dat_i[7:0];
        if (wr && wb_adr_i == `CWSS_OFF_POL) pol <= wb_dat_i[7:0];
        if (wr && wb_adr_i == `CWSS_OFF_SHDN) shd <= wb_dat_i[7:0];
        if (wr && wb_adr_i == `CWSS_OFF_SRC) src <= wb_dat_i[7:0];
        if (wr && wb_adr_i == `CWSS_OFF_STR) str <= wb_dat_i[7:0];
        if (wr && wb_adr_i == `CWSS_OFF_SEL) sel <= wb_dat_i[7:0];
        if (wr && wb_adr_i == `CWSS_OFF_CLK) ck <= wb_dat_i[0];
    end
end

default clocking cb @(posedge ref_clk); endclocking
default disable iff (sys_rst);

a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held");
a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not answered");
a_steer_drive: assert property (
    calm && ctl[7] && ctl[2:0] == 3'h0
    |=> steered_out == $past(ex) && steered_oe == 4'hF)
    else $error("steered level wrong"); // Also
a_other_mode: assert property (
    calm && ctl[7] && ctl[2:1] != 2'h0
    |=> steered_out == pol[3:0] && steered_oe == 4'hF)
    else $error("steering applied outside steering modes");
a_masked_src: assert property (
    calm && ctl[7] && ctl[2:0] == 3'h0 && (|(~src[4:0] & sd))
    |=> steered_oe == 4'hF)
    else $error("masked source tripped"); // Also
a_trip_shut: assert property (
    hot && shd[5:2] == 4'h5 && !ck && !module_clk_sel
    |-> ##[1:3] steered_oe == 4'h0)
    else $error("no shutdown on enabled source");
a_osc_gate: assert property (
    ck && module_clk_sel && !$rose(internal_fast_oscillator)
    |=> $stable(steered_out) && $stable(steered_oe))
    else $error("output moved without oscillator edge");
a_clk_copy: assert property (
    wr && wb_adr_i == `CWSS_OFF_CLK |=> ##1 module_clk_sel == $past(wb_dat_i[0], 2))
    else $error("clock select not reported");
a_off_idle: assert property (calm && !ctl[7] |=> steered_oe == 4'h0 && steered_out == 4'h0)
    else $error("disabled block drives");

c_trip: cover property (hot ##1 steered_oe == 4'h0);
c_sync: cover property (ctl[7] && ctl[2:0] == 3'h1 && steered_out == 4'hF);
c_osc: cover property (ck && $rose(internal_fast_oscillator));
endmodule // cwss_top_monitor

// File: cwss_top_tb.sv
`timescale 1ns/100ps
`include "cwss_map.vh"
module cwss_top_tb;
reg         ref_clk = 1'b0; // 4 ns clock
reg         sys_rst = 1'b1; // Reset
reg         cyc = 1'b0;     // Bus request
reg         we = 1'b0;      // Direction
reg  [7:0]  adr = 8'h00;    // Address
reg  [31:0] wdat = 32'h0;   // Write data
reg  [15:0] wv = 16'h0000;  // Waveform sources by code
reg  [4:0]  sd = 5'h00;     // Trip sources by enable bit
reg         osc = 1'b0;     // Fast oscillator
reg         res;            // Reserved code
reg  [31:0] rd;             // Last read
wire [31:0] rdat;
wire        ack, ck_sel;
wire [3:0]  s_out, s_oe, pin_lvl;
integer     fail_count = 0;
integer     checked = 0;
integer     i, c, k;

cwss_top cwss_top_i (.ref_clk(ref_clk), .sys_rst(sys_rst), .wb_cyc_i(cyc),
    .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .internal_fast_oscillator(osc), .routed_input_pin(wv[0]),
    .capture_out(wv[1]), .pwm_out(wv[6:3]), .osc_out(wv[7]),
    .cmp1_out(wv[8] | sd[2]), .cmp2_out(wv[9] | sd[3]),
    .logic_cell_out(wv[13:10] | {2'h0, sd[4], 1'b0}),
    .timer_postscale_out(sd[1]), .shutdown_pin_route(sd[0]),
    .steered_out(s_out), .steered_oe(s_oe), .module_clk_sel(ck_sel));
cwss_switch_stage cwss_switch_stage_i (.steered_out(s_out),
    .steered_oe(s_oe), .pin_lvl(pin_lvl));

initial forever #2 ref_clk = ~ref_clk;
////////////////////////////////////////////////////////////////////////////
task conclude;
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
endtask
task chk(input [31:0] seen, input [31:0] exp);
    checked = checked + 1;
    if (seen !== exp) begin
        fail_count = fail_count + 1;
        $display("mismatch at %0t: saw %0h want %0h", $time, seen, exp);
    end
endtask
// One classic cycle; ack and read data are taken at the same rising edge
task bus(input [7:0] a, input w, input [7:0] d);
    integer n;
    @(posedge ref_clk);
    {cyc, we, adr, wdat} <= {1'b1, w, a, 24'h000000, d};
    n = 0;
    @(posedge ref_clk);
    while (ack !== 1'b1 && n < 16) begin
        @(posedge ref_clk);
        n = n + 1;
    end
    if (ack !== 1'b1) begin
        fail_count = fail_count + 1;
        conclude;
    end
    rd = rdat;
    cyc <= 1'b0;
endtask
// Latency is the design's, so allow a few cycles before judging
task pins(input [7:0] x);
    integer n;
    n = 0;
    @(negedge ref_clk);
    while ({s_oe, pin_lvl} !== x && n < 8) begin
        @(negedge ref_clk);
        n = n + 1;
    end
    chk({24'h000000, s_oe, pin_lvl}, {24'h000000, x});
endtask
task rst;
    {sys_rst, wv, sd, osc} <= {1'b1, 16'h0000, 5'h00, 1'b0};
    repeat (16) @(posedge ref_clk);
    sys_rst <= 1'b0;
endtask
////////////////////////////////////////////////////////////////////////////
initial begin
    rst;
    for (i = 0; i < 8; i = i + 1) begin
        bus((i == 7) ? 8'h20 : 8'(i * 4), 1'b0, 8'h00);
        chk(rd, (i == 2) ? 32'h14 : 32'h0);
    end
    for (i = 3; i < 7; i = i + 1) begin
        bus(8'(i * 4), 1'b1, 8'hFF);
        bus(8'(i * 4), 1'b0, 8'h00);
        chk(rd, i == 3 ? 32'h1F : i == 4 ? 32'hFF : i == 5 ? 32'h1 : 32'hF);
    end
    bus(8'h20, 1'b1, 8'hFF);
    bus(8'h20, 1'b0, 8'h00);
    chk(rd, 32'h0);
    $display("test registers done");
    rst;
    bus(`CWSS_OFF_CTRL, 1'b1, 8'h80);
    bus(`CWSS_OFF_STR, 1'b1, 8'h81);
    for (c = 0; c < 16; c = c + 1) begin
        bus(`CWSS_OFF_SEL, 1'b1, 8'(c));
        bus(`CWSS_OFF_POL, 1'b1, 8'(c & 1));
        for (k = 0; k < 2; k = k + 1) begin
            res = (c == 2) || (c > 13);
            @(posedge ref_clk);
            wv <= res ? 16'hFFFF : (k ? ~(16'h0001 << c) : 16'h0001 << c);
            pins({5'h1F, 2'h0, (!res && !k) ^ c[0]});
        end
    end
    $display("test selector done");
    for (i = 0; i < 5; i = i + 1) begin
        rst;
        bus(`CWSS_OFF_CTRL, 1'b1, 8'h80);
        bus(`CWSS_OFF_STR, 1'b1, 8'h0F);
        bus(`CWSS_OFF_SRC, 1'b1, 8'(5'h1F ^ (5'h01 << i)));
        sd <= 5'h01 << i;
        repeat (6) @(posedge ref_clk);
        pins(8'hF0);
        bus(`CWSS_OFF_SRC, 1'b1, 8'(5'h01 << i));
        pins(8'h00);
        bus(`CWSS_OFF_SHDN, 1'b0, 8'h00);
        chk(rd, 32'h94);
        bus(`CWSS_OFF_SHDN, 1'b1, 8'h54);
        sd <= 5'h00;
        repeat (4) @(posedge ref_clk);
        bus(`CWSS_OFF_SHDN, 1'b0, 8'h00);
        chk(rd, 32'h54);
        pins(8'h00);
        @(posedge ref_clk);
        wv <= 16'h0001;
        pins(8'hFF);
    end
    $display("test shutdown done");
    rst;
    bus(`CWSS_OFF_POL, 1'b1, 8'h0F);
    bus(`CWSS_OFF_CTRL, 1'b1, 8'h81);
    bus(`CWSS_OFF_STR, 1'b1, 8'h0F);
    repeat (6) @(posedge ref_clk);
    pins(8'hF0);
    @(posedge ref_clk);
    wv <= 16'h0001;
    @(posedge ref_clk);
    wv <= 16'h0000;
    pins(8'hFF);
    $display("test sync steering done");
    rst;
    bus(`CWSS_OFF_CTRL, 1'b1, 8'h80);
    bus(`CWSS_OFF_STR, 1'b1, 8'h0F);
    bus(`CWSS_OFF_CLK, 1'b1, 8'h01);
    wv <= 16'h0001;
    repeat (8) @(posedge ref_clk);
    pins(8'hF0);
    chk({31'h0, ck_sel}, 32'h1);
    @(posedge ref_clk);
    osc <= 1'b1;
    pins(8'hFF);
    $display("test clock select done");
    rst;
    bus(`CWSS_OFF_POL, 1'b1, 8'h05);
    bus(`CWSS_OFF_STR, 1'b1, 8'hF0);
    for (i = 2; i < 8; i = i + 1) begin
        bus(`CWSS_OFF_CTRL, 1'b1, 8'(8'h80 | i));
        pins(8'hF5);
    end
    bus(`CWSS_OFF_CTRL, 1'b1, 8'h00);
    pins(8'h00);
    bus(`CWSS_OFF_CTRL, 1'b1, 8'h80);
    pins(8'hFF);
    $display("test modes done");
    rst;
    bus(`CWSS_OFF_POL, 1'b1, 8'h05);
    bus(`CWSS_OFF_SHDN, 1'b1, 8'hB8);
    pins(8'hFA);
    bus(`CWSS_OFF_SHDN, 1'b1, 8'h80);
    pins(8'hF5);
    $display("test shutdown levels done");
    conclude;
end
endmodule // cwss_top_tb

bind cwss_top cwss_top_monitor cwss_top_monitor_i (.*);
